// ==== rtl/prc_defs.svh ====
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH
// What this block does
// - start key tapped while stopped starts program; held one second it purges
// - purge runs motor flat out in set direction; key release stops it
// - rate display falls back to volume after two idle seconds
// - edited rate commits on idle or non-arrow key; valid rate blinks and applies
// - committed rate out of range raises error, cleared by next key
// - rate unit changes are refused while pumping
// - direction key reverses at once while stopped, or while running only when target volume is zero
// - separate infuse and withdraw totals; display follows active direction
// - both totals clear on hold-up, subprogram, diameter, clear, power-on, rollover
// - stop before completion pauses with blinking led; start resumes mid-phase
// - non-start key while paused cancels pause once stall is clear; next start begins phase one
// - stall or collar limit pauses, raises alarm, sends message in safe mode
// - any key silences buzzer and clears stall; any start source resumes
// - setup only while stopped; advances on idle two seconds or non-arrow key
// - power-fail restart auto-starts at power-up unless a key is held
// - low-noise bit selects reduced micro-stepping
// - alarm-enable bit lets buzzer sound steadily during stall
// - mode 0 toggles on falling edge, mode 2 on rising edge
// - mode 1 falling starts rising stops; mode 3 falling stops rising starts
// - modes 4 to 7 single edge start or stop
// - modes 8 to 11 level start or stop
// - mode 12 ignores input; 13 and 14 turn stops into program events

// ********************
// register offsets
// ********************
`define PRC_CFG_OFS     12'h000
`define PRC_CMD_OFS     12'h004
`define PRC_RATE_OFS    12'h008
`define PRC_TGT_OFS     12'h00C
`define PRC_STAT_OFS    12'h010
`define PRC_ACCI_OFS    12'h014
`define PRC_ACCW_OFS    12'h018

// ********************
// field positions and reset values
// ********************
`define PRC_CFG_NOISE   0
`define PRC_CFG_ALARM   1
`define PRC_CFG_SAFE    2
`define PRC_CFG_MODE_LO 4
`define PRC_CFG_UNIT_LO 8
`define PRC_CMD_CLR     0
`define PRC_CMD_RUN     1
`define PRC_CMD_STOP    2
`define PRC_CFG_RST     10'h000
`define PRC_RATE_RST    16'h0064
`define PRC_RATE_MAX    16'h2710
`define PRC_ACC_LAST    14'h270F
`define PRC_SETUP_LAST  4'hA

// ********************
// timing
// ********************
`define PRC_CLK_KHZ     100000
`define PRC_HOLD_MS     1000
`define PRC_IDLE_MS     2000
`endif

// ==== rtl/prc_pkg.sv ====
package prc_pkg;
   // run state of the pumping program
   typedef enum logic [2:0] {
      PRC_STOP,
      PRC_HOLD,
      PRC_PURGE,
      PRC_RUN,
      PRC_PAUSE
   } prc_state_e;
   typedef logic [3:0] prc_mode_t;
endpackage

// ==== rtl/prc_top.sv ====
`timescale 1ns/1ns
`include "prc_defs.svh"
module prc_top
   import prc_pkg::*;
#(
   parameter int unsigned HOLD_CYC = `PRC_HOLD_MS * `PRC_CLK_KHZ,
   parameter int unsigned IDLE_CYC = `PRC_IDLE_MS * `PRC_CLK_KHZ
) (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // keypad levels
   input  wire logic        key_start,
   input  wire logic        key_up,
   input  wire logic        key_dir,
   input  wire logic        key_rate,
   input  wire logic        key_setup,
   input  wire logic        key_other,
   // trigger line and sensors
   input  wire logic        trig_in,
   input  wire logic        stall_in,
   input  wire logic        collar_in,
   input  wire logic        vol_tick,
   input  wire logic        diam_chg,
   input  wire logic        subprog_sel,
   // power-fail memory
   input  wire logic        power_fail_restart,
   input  wire logic        was_running,
   // motor and panel
   output logic             motor_run,
   output logic             motor_fast,
   output logic             motor_dir,
   output logic             step_reduced,
   output logic             buzzer,
   output logic             pump_led,
   output logic             pump_led_blink,
   output logic             show_rate,
   output logic             disp_blink,
   output logic             oor_err,
   output logic      [13:0] disp_vol,
   output logic             alarm_msg,
   output logic             prog_event
);
   // ********************
   // state
   // ********************
   prc_state_e  st_reg;
   logic [9:0]  cfg_reg;
   logic [15:0] rate_reg, rate_edit_reg, tgt_reg, phase_vol_reg;
   logic [13:0] acc_inf_reg, acc_wd_reg;
   logic [31:0] hold_cnt_reg, idle_cnt_reg;
   logic [3:0]  setup_idx_reg;
   logic        dir_reg, stall_reg, oor_reg, show_rate_reg, edit_reg, setup_reg;
   logic        boot_reg, s1_reg, s2_reg, s3_reg;
   logic [5:0]  key_q_reg;
   logic [5:0]  key_now, key_pr;
   logic        any_pr, nonarrow_pr, running, stopped, idle_hit, hold_hit;
   logic        wr, rd_setup, cmd_clr, cmd_run, cmd_stop;
   logic        t_start, t_stop, t_tog, t_evt, fall, rise;
   logic        go, halt, done, stall_hit, commit, clr_acc, roll, up_hold;
   prc_mode_t   mode;

   // ********************
   // key press edges
   // ********************
   assign key_now = {key_other, key_setup, key_rate, key_dir, key_up, key_start};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q_reg <= 6'h00;
      end else if (ce) begin
         key_q_reg <= key_now;
      end
   end
   assign key_pr      = key_now & ~key_q_reg;
   assign any_pr      = |key_pr;
   assign nonarrow_pr = key_pr[0] | key_pr[2] | key_pr[3] | key_pr[4] | key_pr[5];
   assign running     = (st_reg == PRC_RUN);
   assign stopped     = (st_reg == PRC_STOP) || (st_reg == PRC_PAUSE);
   assign mode        = prc_mode_t'(cfg_reg[`PRC_CFG_MODE_LO +: 4]);

   // ********************
   // trigger input
   // ********************
   // s1 only feeds s2; edges come from s2 against s3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else if (ce) begin
         s1_reg <= trig_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   assign fall = s3_reg & ~s2_reg;
   assign rise = ~s3_reg & s2_reg;

   // decode of the fifteen trigger modes
   always_comb begin
      t_start = 1'b0;
      t_stop  = 1'b0;
      t_tog   = 1'b0;
      t_evt   = 1'b0;
      unique case (mode)
         4'h0: t_tog = fall;
         4'h1: begin
            t_start = fall;
            t_stop  = rise;
         end
         4'h2: t_tog = rise;
         4'h3: begin
            t_stop  = fall;
            t_start = rise;
         end
         4'h4: t_start = fall;
         4'h5: t_start = rise;
         4'h6: t_stop  = fall;
         4'h7: t_stop  = rise;
         4'h8: t_start = ~s2_reg;
         4'h9: t_start = s2_reg;
         4'hA: t_stop  = ~s2_reg;
         4'hB: t_stop  = s2_reg;
         4'hD: t_evt   = fall;
         default: t_start = 1'b0; // 12, 14 and the unused code: input ignored
      endcase
   end

   // ********************
   // timers
   // ********************
   // hold timer serves both the start-key hold and the up-key clear hold
   assign up_hold  = key_up & stopped & ~show_rate_reg & ~setup_reg;
   assign hold_hit = (hold_cnt_reg == HOLD_CYC - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_reg <= 32'h0000_0000;
      end else if (ce) begin
         if ((st_reg == PRC_HOLD || up_hold) && !hold_hit) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
         end else if (st_reg != PRC_HOLD && !up_hold) begin
            hold_cnt_reg <= 32'h0000_0000;
         end
      end
   end

   // idle timer restarts on every key press
   assign idle_hit = (idle_cnt_reg == IDLE_CYC - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_reg <= 32'h0000_0000;
      end else if (ce) begin
         if (any_pr || idle_hit) begin
            idle_cnt_reg <= 32'h0000_0000;
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // ********************
   // run control
   // ********************
   assign stall_hit = running & (stall_in | collar_in);
   assign done      = running & (tgt_reg != 16'h0000) & (phase_vol_reg >= tgt_reg);
   assign go        = t_start | t_tog | cmd_run |
                      (boot_reg & power_fail_restart & was_running & ~(|key_now));
   assign halt      = (t_stop & (mode != 4'hD)) | t_tog | cmd_stop;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg        <= PRC_STOP;
         phase_vol_reg <= 16'h0000;
         stall_reg     <= 1'b0;
         boot_reg      <= 1'b1;
         prog_event    <= 1'b0;
         alarm_msg     <= 1'b0;
      end else if (ce) begin
         boot_reg   <= 1'b0;
         prog_event <= t_evt | (running & key_pr[0] & (mode == 4'hE));
         alarm_msg  <= stall_hit & cfg_reg[`PRC_CFG_SAFE];
         if (stall_reg && any_pr) begin
            stall_reg <= 1'b0;
         end
         if (running && vol_tick) begin
            phase_vol_reg <= phase_vol_reg + 16'h0001;
         end
         unique case (st_reg)
            PRC_STOP, PRC_PAUSE: begin
               if (st_reg == PRC_STOP && (key_pr[0] || go)) begin
                  phase_vol_reg <= 16'h0000; // fresh start at phase one
               end
               if (key_pr[0]) begin
                  st_reg <= PRC_HOLD;
               end else if (go) begin
                  st_reg <= PRC_RUN;
               end else if (st_reg == PRC_PAUSE && any_pr && !stall_reg) begin
                  st_reg <= PRC_STOP;
               end
            end
            PRC_HOLD: begin
               if (!key_start) begin
                  st_reg <= PRC_RUN;
               end else if (hold_hit) begin
                  st_reg <= PRC_PURGE;
               end
            end
            PRC_PURGE: begin
               if (!key_start) begin
                  st_reg <= PRC_STOP;
               end
            end
            PRC_RUN: begin
               if (stall_hit) begin
                  st_reg    <= PRC_PAUSE;
                  stall_reg <= 1'b1;
               end else if (done) begin
                  st_reg <= PRC_STOP;
               end else if ((key_pr[0] && mode != 4'hE) || halt) begin
                  st_reg <= PRC_PAUSE;
               end
            end
            default: st_reg <= PRC_STOP;
         endcase
      end
   end

   // ********************
   // rate edit and display
   // ********************
   assign commit = edit_reg & (idle_hit | nonarrow_pr);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         show_rate_reg <= 1'b0;
         edit_reg      <= 1'b0;
         rate_edit_reg <= 16'h0000;
         oor_reg       <= 1'b0;
         disp_blink    <= 1'b0;
      end else if (ce) begin
         disp_blink <= 1'b0;
         if (oor_reg && any_pr) begin
            oor_reg <= 1'b0;
         end
         if (commit) begin
            edit_reg      <= 1'b0;
            show_rate_reg <= 1'b0;
            if (rate_edit_reg != 16'h0000 && rate_edit_reg <= `PRC_RATE_MAX) begin
               disp_blink <= 1'b1;
            end else begin
               oor_reg <= 1'b1;
            end
         end else if (running && key_pr[3]) begin
            show_rate_reg <= 1'b1;
            rate_edit_reg <= rate_reg;
         end else if (show_rate_reg && key_pr[1]) begin
            edit_reg      <= 1'b1;
            rate_edit_reg <= rate_edit_reg + 16'h0001;
         end else if (show_rate_reg && (idle_hit || !running)) begin
            show_rate_reg <= 1'b0;
         end
      end
   end

   // ********************
   // setup walk
   // ********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_reg     <= 1'b0;
         setup_idx_reg <= 4'h0;
      end else if (ce) begin
         if (!setup_reg && stopped && key_pr[4]) begin
            setup_reg     <= 1'b1;
            setup_idx_reg <= 4'h0;
         end else if (setup_reg && (!stopped || ((idle_hit || nonarrow_pr) &&
                                  setup_idx_reg == `PRC_SETUP_LAST))) begin
            setup_reg <= 1'b0;
         end else if (setup_reg && (idle_hit || nonarrow_pr)) begin
            setup_idx_reg <= setup_idx_reg + 4'h1;
         end
      end
   end

   // ********************
   // direction and volume totals
   // ********************
   assign roll    = vol_tick & (running | st_reg == PRC_PURGE) &
                    ((dir_reg ? acc_wd_reg : acc_inf_reg) == `PRC_ACC_LAST);
   assign clr_acc = (up_hold & hold_hit) | subprog_sel | diam_chg | cmd_clr | roll;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_reg     <= 1'b0;
         acc_inf_reg <= 14'h0000; // power-on clear
         acc_wd_reg  <= 14'h0000;
      end else if (ce) begin
         if (key_pr[2] && (stopped || (running && tgt_reg == 16'h0000))) begin
            dir_reg <= ~dir_reg;
         end
         if (clr_acc) begin
            acc_inf_reg <= 14'h0000;
            acc_wd_reg  <= 14'h0000;
         end else if (vol_tick && (running || st_reg == PRC_PURGE)) begin
            if (dir_reg) begin
               acc_wd_reg <= acc_wd_reg + 14'h0001;
            end else begin
               acc_inf_reg <= acc_inf_reg + 14'h0001;
            end
         end
      end
   end

   // ********************
   // apb registers
   // ********************
   assign wr       = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign cmd_clr  = wr & (paddr == `PRC_CMD_OFS) & pwdata[`PRC_CMD_CLR];
   assign cmd_run  = wr & (paddr == `PRC_CMD_OFS) & pwdata[`PRC_CMD_RUN];
   assign cmd_stop = wr & (paddr == `PRC_CMD_OFS) & pwdata[`PRC_CMD_STOP];
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~(paddr == `PRC_CFG_OFS || paddr == `PRC_CMD_OFS ||
                     paddr == `PRC_RATE_OFS || paddr == `PRC_TGT_OFS ||
                     (!pwrite && (paddr == `PRC_STAT_OFS || paddr == `PRC_ACCI_OFS ||
                     paddr == `PRC_ACCW_OFS)));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg  <= `PRC_CFG_RST;
         rate_reg <= `PRC_RATE_RST;
         tgt_reg  <= 16'h0000;
      end else if (ce) begin
         if (wr && paddr == `PRC_CFG_OFS) begin
            cfg_reg[7:0] <= pwdata[7:0];
            if (!running) begin
               cfg_reg[9:8] <= pwdata[9:8]; // units frozen while pumping
            end
         end
         if (commit && !oor_next(rate_edit_reg)) begin
            rate_reg <= rate_edit_reg; // applied at once
         end else if (wr && paddr == `PRC_RATE_OFS) begin
            rate_reg <= pwdata[15:0];
         end
         if (wr && paddr == `PRC_TGT_OFS) begin
            tgt_reg <= pwdata[15:0];
         end
      end
   end

   function automatic logic oor_next(input logic [15:0] r);
      oor_next = (r == 16'h0000) || (r > `PRC_RATE_MAX);
   endfunction

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && rd_setup) begin
         unique case (paddr)
            `PRC_CFG_OFS:  prdata <= {22'h000000, cfg_reg};
            `PRC_RATE_OFS: prdata <= {16'h0000, rate_reg};
            `PRC_TGT_OFS:  prdata <= {16'h0000, tgt_reg};
            `PRC_STAT_OFS: prdata <= {20'h00000, setup_idx_reg, setup_reg, show_rate_reg,
                                      dir_reg, oor_reg, stall_reg, st_reg};
            `PRC_ACCI_OFS: prdata <= {18'h00000, acc_inf_reg};
            `PRC_ACCW_OFS: prdata <= {18'h00000, acc_wd_reg};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ********************
   // outputs
   // ********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_run      <= 1'b0;
         motor_fast     <= 1'b0;
         motor_dir      <= 1'b0;
         step_reduced   <= 1'b0;
         buzzer         <= 1'b0;
         pump_led       <= 1'b0;
         pump_led_blink <= 1'b0;
         disp_vol       <= 14'h0000;
      end else if (ce) begin
         motor_run      <= running | (st_reg == PRC_PURGE);
         motor_fast     <= (st_reg == PRC_PURGE);
         motor_dir      <= dir_reg;
         step_reduced   <= cfg_reg[`PRC_CFG_NOISE];
         buzzer         <= cfg_reg[`PRC_CFG_ALARM] & stall_reg;
         pump_led       <= running;
         pump_led_blink <= (st_reg == PRC_PAUSE);
         disp_vol       <= dir_reg ? acc_wd_reg : acc_inf_reg;
      end
   end
   assign show_rate = show_rate_reg;
   assign oor_err   = oor_reg;

   // ********************
   // checks
   // ********************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence seq_holding;
      (st_reg == PRC_HOLD) && key_start && ce && hold_hit;
   endsequence
   AST_HOLD_PURGE: assert property (seq_holding |=> st_reg == PRC_PURGE)
      else $error("held start did not purge");
   AST_PURGE_STOP: assert property ((st_reg == PRC_PURGE) && !key_start && ce
      |=> st_reg == PRC_STOP ##1 !motor_run)
      else $error("purge did not stop on release");
   AST_STALL_PAUSE: assert property (stall_hit && ce
      |=> st_reg == PRC_PAUSE && stall_reg)
      else $error("stall did not pause");
   AST_BUZZER: assert property (ce && stall_reg && !cfg_reg[`PRC_CFG_ALARM] |=> !buzzer)
      else $error("buzzer sounded while alarms off");
   AST_TOGGLE0: assert property (ce && mode == 4'h0 && fall && running && !stall_hit && !done
      && !key_pr[0] |=> st_reg == PRC_PAUSE)
      else $error("falling edge did not toggle");
   AST_CLEAR: assert property (ce && cmd_clr |=> acc_inf_reg == 14'h0000
      && acc_wd_reg == 14'h0000)
      else $error("totals not cleared");
   AST_DIR_LOCK: assert property (ce && running && tgt_reg != 16'h0000
      |=> $stable(dir_reg))
      else $error("direction changed with target set");
   AST_OOR: assert property (ce && commit && oor_next(rate_edit_reg)
      |=> oor_reg && $stable(rate_reg))
      else $error("bad rate accepted");
   AST_UNITS: assert property (ce && running |=> $stable(cfg_reg[9:8]))
      else $error("units changed while pumping");
endmodule

// ==== verif/prc_opr_model.sv ====
`timescale 1ns/1ns
// ************************
// keypad operator and trigger line
// ************************
module prc_opr_model (
   // clock
   input  wire logic       pclk,
   // keypad levels, bit 0 start .. bit 5 other
   output logic      [5:0] keys,
   // external trigger level
   output logic            trig
);
   // keys rest released; the line rests high like an idle input
   initial begin
      keys = 6'h00;
      trig = 1'b1;
   end
   // change one key level just after an edge, then let it settle
   task automatic set_key(input int idx, input logic v);
      @(posedge pclk);
      keys[idx] <= v;
      repeat (3) @(posedge pclk);
   endtask
   // short press, well under the hold time
   task automatic tap(input int idx);
      set_key(idx, 1'b1);
      set_key(idx, 1'b0);
   endtask
   // move the line, then wait out the sync delay plus a margin
   task automatic drive_trig(input logic v);
      @(posedge pclk);
      trig <= v;
      repeat (6) @(posedge pclk);
   endtask
endmodule

// ==== verif/pump_run_trigger_control_tb.sv ====
`timescale 1ns/1ns
`include "prc_defs.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
 $display("BAD %s exp %h got %h", nm, ex, got); bad_count++; end end
module pump_run_trigger_control_tb;
   import prc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        err, stall_in, collar_in, vol_tick, diam_chg, seen_alarm, trig;
   logic [5:0]  keys;
   logic        m_run, m_fast, m_dir, step_red, buzzer, led, led_blink;
   logic        ce, subprog, pfail, was_run, show_rate_w, blink_w, oor_w, evt_w;
   logic        alarm_msg_w, seen_blink, seen_evt;
   logic [13:0] dvol;
   int          bad_count, n_compared, cyc;
   // ************************
   // clock, timeout, alarm pulse catcher
   // ************************
   always #5 pclk = ~pclk;
   // short alarm pulse would be missed by a later look
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (alarm_msg_w === 1'b1) seen_alarm <= 1'b1;
      if (blink_w === 1'b1) seen_blink <= 1'b1;
      if (evt_w === 1'b1) seen_evt <= 1'b1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   prc_opr_model opr (.pclk(pclk), .keys(keys), .trig(trig));
   prc_top #(.HOLD_CYC(20), .IDLE_CYC(40)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .key_start(keys[0]), .key_up(keys[1]), .key_dir(keys[2]),
      .key_rate(keys[3]), .key_setup(keys[4]), .key_other(keys[5]), .trig_in(trig),
      .stall_in(stall_in), .collar_in(collar_in), .vol_tick(vol_tick), .diam_chg(diam_chg),
      .subprog_sel(subprog), .power_fail_restart(pfail), .was_running(was_run),
      .motor_run(m_run), .motor_fast(m_fast), .motor_dir(m_dir), .step_reduced(step_red),
      .buzzer(buzzer), .pump_led(led), .pump_led_blink(led_blink), .show_rate(show_rate_w),
      .disp_blink(blink_w), .oor_err(oor_w), .disp_vol(dvol), .alarm_msg(alarm_msg_w),
      .prog_event(evt_w));
   // ************************
   // apb master: hold request until pready seen high
   // ************************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout may end this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_regs();
      apb(1'b0, `PRC_RATE_OFS, 32'h0);
      `CHK("rate reset", 32'h00000064, rd)
      apb(1'b0, 12'h01C, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      apb(1'b1, `PRC_STAT_OFS, 32'h7);
      `CHK("ro write err", 1'b1, err)
   endtask
   task automatic t_purge();
      opr.set_key(0, 1'b1);
      repeat (30) @(posedge pclk);
      `CHK("motor_fast", 1'b1, m_fast)
      apb(1'b0, `PRC_STAT_OFS, 32'h0);
      `CHK("state purge", PRC_PURGE, rd[2:0])
      `CHK("purge dir", 1'b0, m_dir)
      opr.set_key(0, 1'b0);
      `CHK("motor_run off", 1'b0, m_run)
   endtask
   task automatic t_stall();
      apb(1'b1, `PRC_CFG_OFS, 32'h7);
      // output register follows the config one edge later
      repeat (2) @(posedge pclk);
      `CHK("step_reduced", 1'b1, step_red)
      opr.tap(0);
      `CHK("running", 1'b1, m_run)
      `CHK("led on", 1'b1, led)
      collar_in <= 1'b1;
      repeat (5) @(posedge pclk);
      collar_in <= 1'b0;
      `CHK("buzzer on", 1'b1, buzzer)
      `CHK("led blink", 1'b1, led_blink)
      `CHK("alarm msg", 1'b1, seen_alarm)
      apb(1'b0, `PRC_STAT_OFS, 32'h0);
      `CHK("paused", PRC_PAUSE, rd[2:0])
      opr.tap(5);
      `CHK("buzzer off", 1'b0, buzzer)
      apb(1'b0, `PRC_STAT_OFS, 32'h0);
      `CHK("still paused", PRC_PAUSE, rd[2:0])
      opr.tap(5);
      `CHK("blink off", 1'b0, led_blink)
      apb(1'b0, `PRC_STAT_OFS, 32'h0);
      `CHK("stopped", PRC_STOP, rd[2:0])
      opr.tap(4);
      opr.tap(5);
      apb(1'b0, `PRC_STAT_OFS, 32'h0);
      `CHK("setup step", 5'h03, rd[11:7])
   endtask
   task automatic t_trig();
      apb(1'b1, `PRC_CFG_OFS, 32'h10);
      opr.drive_trig(1'b0);
      `CHK("mode1 fall", 1'b1, m_run)
      opr.drive_trig(1'b1);
      `CHK("mode1 rise", 1'b0, m_run)
      apb(1'b1, `PRC_CFG_OFS, 32'hC0);
      opr.drive_trig(1'b0);
      `CHK("mode12", 1'b0, m_run)
      apb(1'b1, `PRC_CFG_OFS, 32'h00);
      opr.drive_trig(1'b1);
      `CHK("mode0 rise", 1'b0, m_run)
      opr.drive_trig(1'b0);
      `CHK("mode0 fall", 1'b1, m_run)
   endtask
   // rate display, edit commit, range error, unit lock, key event
   task automatic t_rate();
      apb(1'b1, `PRC_CFG_OFS, 32'h300);
      apb(1'b0, `PRC_CFG_OFS, 32'h0);
      `CHK("units locked", 32'h0, rd)
      opr.tap(3);
      `CHK("show rate", 1'b1, show_rate_w)
      repeat (45) @(posedge pclk);
      `CHK("rate timeout", 1'b0, show_rate_w)
      opr.tap(3);
      opr.tap(1);
      opr.tap(5);
      apb(1'b0, `PRC_RATE_OFS, 32'h0);
      `CHK("rate commit", 32'h00000065, rd)
      `CHK("commit blink", 1'b1, seen_blink)
      apb(1'b1, `PRC_RATE_OFS, 32'h2710);
      opr.tap(3);
      opr.tap(1);
      repeat (45) @(posedge pclk);
      `CHK("oor set", 1'b1, oor_w)
      apb(1'b0, `PRC_RATE_OFS, 32'h0);
      `CHK("rate kept", 32'h00002710, rd)
      opr.tap(5);
      `CHK("oor clear", 1'b0, oor_w)
      apb(1'b1, `PRC_CFG_OFS, 32'hE0);
      opr.tap(0);
      `CHK("key evt runs", 1'b1, m_run)
      `CHK("key evt", 1'b1, seen_evt)
      apb(1'b1, `PRC_CFG_OFS, 32'h0);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         vol_tick <= 1'b1;
         @(posedge pclk);
         vol_tick <= 1'b0;
      end
   endtask
   task automatic t_acc();
      tick(3);
      apb(1'b0, `PRC_ACCI_OFS, 32'h0);
      `CHK("acc inf", 32'h3, rd)
      opr.tap(2);
      tick(2);
      apb(1'b0, `PRC_ACCW_OFS, 32'h0);
      `CHK("acc wd", 32'h2, rd)
      `CHK("dir swap", 1'b1, m_dir)
      `CHK("disp wd", 14'h0002, dvol)
      apb(1'b1, `PRC_TGT_OFS, 32'h100);
      opr.tap(2);
      `CHK("dir locked", 1'b1, m_dir)
      apb(1'b1, `PRC_TGT_OFS, 32'h0);
      opr.tap(2);
      `CHK("disp inf", 14'h0003, dvol)
      apb(1'b1, `PRC_CMD_OFS, 32'h1);
      apb(1'b0, `PRC_ACCI_OFS, 32'h0);
      `CHK("acc clear", 32'h0, rd)
      tick(1);
      @(posedge pclk);
      diam_chg <= 1'b1;
      @(posedge pclk);
      diam_chg <= 1'b0;
      apb(1'b0, `PRC_ACCI_OFS, 32'h0);
      `CHK("acc diam", 32'h0, rd)
      tick(1);
      @(posedge pclk);
      subprog <= 1'b1;
      @(posedge pclk);
      subprog <= 1'b0;
      apb(1'b0, `PRC_ACCI_OFS, 32'h0);
      `CHK("acc subprog", 32'h0, rd)
      // enable low: ticks must be lost
      ce <= 1'b0;
      tick(2);
      ce <= 1'b1;
      apb(1'b0, `PRC_ACCI_OFS, 32'h0);
      `CHK("ce freeze", 32'h0, rd)
   endtask
   task automatic pulse_reset();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   // line parked high first so the reset synchroniser sees no false edge
   task automatic t_pfail();
      opr.drive_trig(1'b1);
      pfail <= 1'b1;
      was_run <= 1'b1;
      pulse_reset();
      `CHK("auto start", 1'b1, m_run)
      opr.set_key(5, 1'b1);
      pulse_reset();
      `CHK("key blocks start", 1'b0, m_run)
      opr.set_key(5, 1'b0);
   endtask
   task automatic stop_test();
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ************************
   // main sequence
   // ************************
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {stall_in, collar_in, vol_tick, diam_chg, seen_alarm} = '0;
      {subprog, pfail, was_run, seen_blink, seen_evt} = '0;
      ce = 1'b1;
      bad_count = 0;
      n_compared = 0;
      cyc = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_purge();
      t_stall();
      t_trig();
      t_rate();
      t_acc();
      t_pfail();
      stop_test();
   end
endmodule
